// [rtl/acpc_pkg.sv]
// package: register map, fields and timing for conversion/power control
package acpc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] CNT_OFS = 8'h08;
   // control field positions
   localparam int CTRL_USE_REG_BIT = 0;
   localparam int CTRL_PD_BIT = 1;
   localparam int CTRL_LOWPWR_BIT = 2;
   localparam int CTRL_REFOFF_BIT = 3;
   localparam int CTRL_BUFOFF_BIT = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // timing: conversion phase length
   localparam int CLK_MHZ = 250;
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic internal_ref_en;
      logic ref_buffer_en;
      logic analog_on;
      logic power_down;
   } acpc_pwr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_PD = 3'b100
   } acpc_state_t;
endpackage

// [rtl/acpc_apb.sv]
// apb slave for control, status and conversion count
`timescale 1ns/10ps
module acpc_apb
   import acpc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [7:0] i_status,
   input wire logic [CNT_W-1:0] i_count,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output logic [4:0] o_ctrl
);
   logic [4:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic access;
   logic wr_access;
   logic mapped;

   assign access = i_psel & ~i_penable;
   // write lands only on the completing edge, never on the setup edge
   assign wr_access = i_psel & i_penable & i_pwrite;
   assign mapped = (i_paddr == CTRL_OFS) | (i_paddr == STAT_OFS) | (i_paddr == CNT_OFS);

   always_comb begin
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      // data prepared in setup so the access phase answers with pready high at once
      if (wr_access && (i_paddr == CTRL_OFS)) begin
         ctrl_d = i_pwdata[4:0];
      end
      if (access) begin
         err_d = ~mapped;
         rdata_d = 32'h0000_0000;
         if (!i_pwrite) begin
            unique case (1'b1)
               (i_paddr == CTRL_OFS): rdata_d = {27'h0000000, ctrl_q};
               (i_paddr == STAT_OFS): rdata_d = {24'h000000, i_status};
               (i_paddr == CNT_OFS): rdata_d = {{(32-CNT_W){1'b0}}, i_count};
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= CTRL_RST;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (i_ce) begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end

   assign o_prdata = rdata_q;
   assign o_pslverr = err_q;
   assign o_ctrl = ctrl_q;
endmodule

// [rtl/acpc_top.sv]
// conversion start and power-mode control with apb registers
// How it works
// RULE_01 - both reference and buffer off selects low enable bandgap and buffer.
// RULE_02 - reference off high with buffer off low disables only the bandgap, buffer runs from its input.
// RULE_03 - both selects high disable bandgap and buffer.
// RULE_04 - each select steers only its own circuit.
// RULE_05 - in low-power sampling mode analog power drops at conversion end and stays down in acquisition.
// RULE_06 - the host interface keeps working during acquisition at reduced power.
// RULE_07 - power-down high places the device in its minimum-current state.
// RULE_08 - power-down waits for a running conversion and the bus stays active.
// RULE_09 - a configuration register bit can request power-down like the pin.
// RULE_10 - when configured from the register the power-down pin is ignored.
// RULE_11 - a falling edge on the active-low start input starts one conversion.
// RULE_12 - a started conversion is neither restarted nor aborted.
// RULE_13 - start handling ignores chip select and read enable.
// RULE_14 - a busy flag spans start edge to completion and masks further starts.
`timescale 1ns/10ps
module acpc_top
   import acpc_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_convert_start_n,
   input wire logic i_power_down_pin,
   input wire logic i_internal_ref_off,
   input wire logic i_ref_buffer_off,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   output logic o_busy,
   output logic o_internal_ref_en,
   output logic o_ref_buffer_en,
   output logic o_analog_on,
   output logic o_power_down
);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

   acpc_state_t state_q, state_d;
   logic [CNT_W-1:0] tmr_q, tmr_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic start_n_q;
   logic acq_low_q, acq_low_d;
   acpc_pwr_t pwr_q, pwr_d;
   logic [4:0] ctrl;
   logic [7:0] status;
   logic fall;
   logic pd_req;
   logic ref_off, buf_off;
   logic unused_ok;

   // cs/rd deliberately unused: conversion does not care about the read port
   assign unused_ok = i_cs_n ^ i_rd_n; // [RULE_13]

   acpc_apb u_apb (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .i_status(status),
      .i_count(cnt_q),
      .o_prdata(o_prdata),
      .o_pslverr(o_pslverr),
      .o_ctrl(ctrl)
   );

   assign fall = start_n_q & ~i_convert_start_n; // [RULE_11]
   // pin ignored in register mode
   assign pd_req = ctrl[CTRL_USE_REG_BIT] ? ctrl[CTRL_PD_BIT] : i_power_down_pin; // [RULE_09] [RULE_10] [RULE_07]
   assign ref_off = ctrl[CTRL_USE_REG_BIT] ? ctrl[CTRL_REFOFF_BIT] : i_internal_ref_off;
   assign buf_off = ctrl[CTRL_USE_REG_BIT] ? ctrl[CTRL_BUFOFF_BIT] : i_ref_buffer_off;
   assign status = {3'h0, unused_ok & 1'b0, pwr_q.power_down, pwr_q.analog_on, acq_low_q, state_q == ST_CONV};

   always_comb begin
      state_d = state_q;
      tmr_d = tmr_q;
      cnt_d = cnt_q;
      acq_low_d = acq_low_q;
      unique case (state_q)
         ST_IDLE: begin
            if (pd_req) begin
               state_d = ST_PD; // [RULE_07]
            end else if (fall) begin
               state_d = ST_CONV; // [RULE_11] [RULE_14]
               tmr_d = '0;
               acq_low_d = 1'b0;
            end
         end
         ST_CONV: begin
            // no exit but completion; pd waits, new edges are ignored
            if (tmr_q == CONV_LAST) begin // [RULE_12] [RULE_08]
               state_d = pd_req ? ST_PD : ST_IDLE;
               cnt_d = cnt_q + 1'b1;
               acq_low_d = ctrl[CTRL_LOWPWR_BIT]; // [RULE_05]
            end else begin
               tmr_d = tmr_q + 1'b1;
            end
         end
         ST_PD: begin
            if (!pd_req) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (!ctrl[CTRL_LOWPWR_BIT]) begin
         acq_low_d = 1'b0;
      end
   end

   always_comb begin
      pwr_d.power_down = (state_d == ST_PD); // [RULE_07]
      pwr_d.internal_ref_en = ~ref_off & ~pwr_d.power_down; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
      pwr_d.ref_buffer_en = ~buf_off & ~pwr_d.power_down; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
      pwr_d.analog_on = ~pwr_d.power_down & ~acq_low_d; // [RULE_05]
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         tmr_q <= '0;
         cnt_q <= '0;
         start_n_q <= 1'b1;
         acq_low_q <= 1'b0;
         pwr_q <= '0;
      end else if (i_ce) begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         cnt_q <= cnt_d;
         start_n_q <= i_convert_start_n;
         acq_low_q <= acq_low_d;
         pwr_q <= pwr_d;
      end
   end

   // bus never gated by power state
   assign o_pready = 1'b1; // [RULE_06] [RULE_08]
   assign o_busy = (state_q == ST_CONV); // [RULE_14]
   assign o_internal_ref_en = pwr_q.internal_ref_en;
   assign o_ref_buffer_en = pwr_q.ref_buffer_en;
   assign o_analog_on = pwr_q.analog_on;
   assign o_power_down = pwr_q.power_down;

   // checker helpers, read only by the assertions below
   logic seen_q;
   logic [CNT_W-1:0] busy_len_q, busy_len_d;

   // counts busy cycles so the length check needs no long repetition
   always_comb begin
      busy_len_d = busy_len_q;
      if (i_ce) begin
         if (o_busy) begin
            busy_len_d = busy_len_q + 1'b1;
         end else begin
            busy_len_d = '0;
         end
      end
   end

   // seen_q masks the first edge after reset, where $past still holds reset-time values
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         seen_q <= 1'b0;
         busy_len_q <= '0;
      end else begin
         seen_q <= 1'b1;
         busy_len_q <= busy_len_d;
      end
   end

   AST_BUSY_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_12]
      i_ce && !o_busy && busy_len_q != '0 |-> busy_len_q == CONV_LAST + 1'b1)
      else $error("busy length wrong");

   AST_BUSY_MAX: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_14]
      o_busy |-> busy_len_q <= CONV_LAST)
      else $error("busy too long");

   AST_START: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_11]
      i_ce && fall && state_q == ST_IDLE && !pd_req |=> o_busy) else $error("start edge lost");

   AST_IDLE_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_11]
      i_ce && state_q == ST_IDLE && !fall && !pd_req |=> !o_busy)
      else $error("start without edge");

   AST_NO_ABORT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_08]
      i_ce && o_busy && tmr_q != CONV_LAST |=> o_busy) else $error("conversion aborted");

   AST_NO_RESTART: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_12]
      i_ce && o_busy && tmr_q != CONV_LAST |=> tmr_q == $past(tmr_q) + 1'b1)
      else $error("conversion restarted");

   AST_CONV_DONE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_14]
      i_ce && o_busy && tmr_q == CONV_LAST |=> !o_busy && cnt_q == $past(cnt_q) + 1'b1)
      else $error("conversion end wrong");

   AST_PD_ENTER: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      i_ce && state_q == ST_IDLE && pd_req |=> o_power_down && !o_analog_on) else $error("no power down");

   AST_PD_FORCE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      o_power_down |-> !o_internal_ref_en && !o_ref_buffer_en && !o_analog_on)
      else $error("power down leaves analog on");

   AST_PD_STATE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      o_power_down == (state_q == ST_PD))
      else $error("power down flag off state");

   AST_PD_NO_CONV: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      i_ce && state_q == ST_PD |=> !o_busy)
      else $error("conversion in power down");

   AST_PD_EXIT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      i_ce && state_q == ST_PD && !pd_req |=> !o_power_down)
      else $error("power down stuck");

   AST_PIN_PD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_07]
      i_ce && !ctrl[CTRL_USE_REG_BIT] && i_power_down_pin && state_q == ST_IDLE |=> o_power_down)
      else $error("pin power down ignored");

   AST_PD_DEFER: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_08]
      i_ce && o_busy && tmr_q == CONV_LAST && pd_req |=> o_power_down && !o_busy)
      else $error("deferred power down lost");

   AST_REG_PD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_09]
      i_ce && ctrl[CTRL_USE_REG_BIT] && ctrl[CTRL_PD_BIT] && state_q == ST_IDLE |=> o_power_down)
      else $error("register power down ignored");

   AST_RD_LIVE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_06]
      i_ce && i_psel && !i_penable && !i_pwrite && i_paddr == STAT_OFS |=> o_prdata[3:0] == $past(status[3:0]))
      else $error("status read lost");

   AST_REF_ON: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_01]
      seen_q && $past(i_ce) && !o_power_down && !$past(ref_off) && !$past(buf_off)
      |-> o_internal_ref_en && o_ref_buffer_en)
      else $error("internal reference not on");

   AST_REF_EXT: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_02]
      seen_q && $past(i_ce) && $past(ref_off) && !$past(buf_off) && !o_power_down
      |-> !o_internal_ref_en && o_ref_buffer_en)
      else $error("external reference decode wrong");

   AST_ALL_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_03]
      seen_q && $past(i_ce) && $past(ref_off) && $past(buf_off) |-> !o_internal_ref_en && !o_ref_buffer_en)
      else $error("reference not fully off");

   AST_REF_MAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_04]
      seen_q && !o_power_down && !$past(o_power_down) |-> o_internal_ref_en != $past(ref_off) || !$past(i_ce))
      else $error("ref enable mismatch");

   AST_BUF_MAP: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_04]
      seen_q && $past(i_ce) && !o_power_down |-> o_ref_buffer_en == !$past(buf_off))
      else $error("buffer enable mismatch");

   AST_CONV_POWER: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_05]
      i_ce && o_busy && tmr_q != CONV_LAST |=> o_analog_on)
      else $error("analog off during conversion");

   AST_ACQ_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_05]
      i_ce && state_q != ST_CONV && acq_low_q && ctrl[CTRL_LOWPWR_BIT] && !fall |=> !o_analog_on)
      else $error("acquisition power not held low");

   // clock enable low must freeze the conversion state
   AST_FREEZE: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_14]
      !i_ce |=> $stable(state_q) && $stable(cnt_q) && $stable(tmr_q))
      else $error("state moved while frozen");

   AST_LOWPWR: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_05]
      i_ce && o_busy && tmr_q == CONV_LAST && ctrl[CTRL_LOWPWR_BIT] |=> !o_analog_on)
      else $error("no drop after conversion");
   AST_PIN_IGNORED: assert property (@(posedge i_clk) disable iff (!i_resetn) // [RULE_10]
      i_ce && ctrl[CTRL_USE_REG_BIT] && !ctrl[CTRL_PD_BIT] && state_q == ST_IDLE && !fall |=> !o_power_down)
      else $error("pin used in register mode");
endmodule

// [verification/acpc_host_model.sv]
// host model giving the active-low start edges
`timescale 1ns/10ps
module acpc_host_model (
   input wire logic i_clk,
   input wire logic i_go,
   output logic o_convert_start_n
);
   logic [1:0] step_q = 2'h0;
   // low for two cycles then high again, so every request is one clean falling edge
   always_ff @(posedge i_clk) begin
      step_q <= i_go ? 2'h1 : ((step_q == 2'h0) ? 2'h0 : step_q + 2'h1);
   end
   assign o_convert_start_n = !((step_q == 2'h1) || (step_q == 2'h2));
endmodule

// [verification/tb_top.sv]
// self-checking bench for conversion start and power control
`timescale 1ns/10ps
module tb_top;
   import acpc_pkg::*;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, pd_pin = 1'b0;
   logic ref_off = 1'b0, buf_off = 1'b0, cs_n = 1'b1, rd_n = 1'b1, start_n, er, ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, busy, ref_en, buf_en, ana_on, pwr_dn;
   int fails = 0, total_checks = 0, n;
   always #2 i_clk = ~i_clk;
   acpc_host_model host_u (.i_clk(i_clk), .i_go(go), .o_convert_start_n(start_n));
   acpc_top #(.CONV_CYCLES(8)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_convert_start_n(start_n), .i_power_down_pin(pd_pin),
      .i_internal_ref_off(ref_off), .i_ref_buffer_off(buf_off), .i_cs_n(cs_n), .i_rd_n(rd_n),
      .o_busy(busy), .o_internal_ref_en(ref_en), .o_ref_buffer_en(buf_en), .o_analog_on(ana_on),
      .o_power_down(pwr_dn));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1 && w < 20) begin
         w++;
         @(posedge i_clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // counts busy cycles over a window; a second edge, and with mid_pd set a pd request, land mid-conversion
   task automatic conv(input logic mid_pd);
      n = 0;
      go <= 1'b1;
      for (int k = 0; k < 30; k++) begin
         @(posedge i_clk);
         go <= (k == 4);
         if (k == 4) pd_pin <= mid_pd;
         if (busy === 1'b1) n++;
      end
   endtask
   initial begin
      #20000;
      fails++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h2428CEE9));
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      chk(busy, 1'b0);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0);
      for (int c = 0; c < 4; c++) begin
         ref_off <= c[0];
         buf_off <= c[1];
         repeat (3) @(posedge i_clk);
         chk({ref_en, buf_en}, {!c[0], !c[1]});
      end
      ref_off <= 1'b0;
      buf_off <= 1'b0;
      $display("reference decode done");
      repeat (4) begin
         cs_n <= 1'($urandom);
         rd_n <= 1'($urandom);
         conv(1'b0);
         chk(n, 8);
      end
      $display("conversion done");
      ce <= 1'b0;
      conv(1'b0);
      chk(n, 0);
      ce <= 1'b1;
      $display("clock enable done");
      apb(1'b1, CTRL_OFS, 32'h4);
      conv(1'b0);
      chk(ana_on, 1'b0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(rd, 32'h2);
      $display("low power done");
      apb(1'b1, CTRL_OFS, 32'h0);
      conv(1'b1);
      chk(n, 8);
      chk({pwr_dn, ref_en, buf_en}, 3'b100);
      apb(1'b0, CNT_OFS, 32'h0);
      chk(rd, 32'h6);
      conv(1'b1);
      chk(n, 0);
      $display("power down done");
      apb(1'b1, CTRL_OFS, 32'h3);
      pd_pin <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk(pwr_dn, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h9);
      pd_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk({pwr_dn, ref_en, buf_en}, 3'b001);
      apb(1'b0, 8'h0C, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("register mode done");
      give_verdict();
   end
endmodule
